// file: logic/dual_channel_muxed_adc_output.sv
`default_nettype none

module sample_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic [PW-1:0]    wr_ptr_reg;
   logic [PW-1:0]    wr_ptr_next;
   logic [PW-1:0]    rd_ptr_reg;
   logic [PW-1:0]    rd_ptr_next;
   logic [CW-1:0]    count_reg;
   logic [CW-1:0]    count_next;
   logic             ready_reg;
   logic             ready_next;
   logic             push;
   logic             pop;

   always_comb begin
      push        = in_valid & ready_reg;
      pop         = out_ready & (count_reg != '0);
      wr_ptr_next = wr_ptr_reg;
      rd_ptr_next = rd_ptr_reg;
      if (push) begin
         wr_ptr_next = (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + PW'(1);
      end
      if (pop) begin
         rd_ptr_next = (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + PW'(1);
      end
      count_next = count_reg + CW'(push) - CW'(pop);
      // Ready from a flop so the source never sees a combinational path
      ready_next = (count_next != CW'(DEPTH));
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
         ready_reg  <= 1'b0;
      end else begin
         wr_ptr_reg <= wr_ptr_next;
         rd_ptr_reg <= rd_ptr_next;
         count_reg  <= count_next;
         ready_reg  <= ready_next;
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   assign in_ready  = ready_reg;
   assign out_valid = (count_reg != '0);
   assign out_data  = mem[rd_ptr_reg];
endmodule // sample_fifo

module dual_channel_muxed_adc_output (
   input  wire logic                             core_clk,
   input  wire logic                             rst_n,
   input  wire logic                             conv_clk,
   input  wire logic                             sample_valid,
   output logic                                  sample_ready,
   input  wire logic [conv_pkg::SAMPLE_W-1:0]    first_channel,
   input  wire logic [conv_pkg::SAMPLE_W-1:0]    second_channel,
   input  wire logic                             power_control_bit0,
   input  wire logic                             power_control_bit1,
   input  wire logic [conv_pkg::REF_IN_W-1:0]    reference_select_input,
   input  wire logic [conv_pkg::SUPPLY_W-1:0]    supply_level_mv,
   output logic [conv_pkg::SAMPLE_W-1:0]         shared_output_bus,
   output logic                                  shared_output_bus_oe,
   output logic                                  channel_indicator,
   output logic [2:0]                            reference_mode,
   output logic                                  reference_buffers_on
);
   localparam int SW = conv_pkg::SAMPLE_W;
   localparam int RW = conv_pkg::RES_W;
   localparam int CL = conv_pkg::CHAIN_LEN;

   logic signed [RW-1:0]  res_a_reg [0:CL-1];
   logic signed [RW-1:0]  res_a_next [0:CL-1];
   logic signed [RW-1:0]  acc_a_reg [0:CL-1];
   logic signed [RW-1:0]  acc_a_next [0:CL-1];
   logic signed [RW-1:0]  res_b_reg [0:CL-1];
   logic signed [RW-1:0]  res_b_next [0:CL-1];
   logic signed [RW-1:0]  acc_b_reg [0:CL-1];
   logic signed [RW-1:0]  acc_b_next [0:CL-1];

   logic                  conv_prev_reg;
   logic [2*SW-1:0]       last_sample_reg;
   logic [2*SW-1:0]       last_sample_next;
   logic [SW-1:0]         bus_reg;
   logic [SW-1:0]         bus_next;
   logic                  bus_oe_reg;
   logic                  indicator_reg;
   logic                  indicator_next;
   conv_pkg::ref_mode_t   ref_mode_reg;
   conv_pkg::ref_mode_t   ref_mode_next;
   logic                  ref_buf_reg;
   logic                  ref_buf_next;
   conv_pkg::power_mode_t pwr_mode_reg;
   conv_pkg::power_mode_t pwr_mode_next;

   logic                  rise;
   logic                  fall;
   logic                  running;
   logic                  fifo_valid;
   logic [2*SW-1:0]       fifo_data;
   logic [2*SW-1:0]       sample_pair;
   logic [conv_pkg::REF_CMP_W-1:0] ref_scaled;
   logic [conv_pkg::REF_CMP_W-1:0] supply_scaled;

   // One redundant 1.5-bit stage: {residue, accumulated digits}
   function automatic logic [2*RW-1:0] resolve(input logic signed [RW-1:0] res,
                                               input logic signed [RW-1:0] acc);
      logic signed [RW:0] dbl;
      logic signed [RW:0] r_n;
      logic signed [RW:0] a_n;
      dbl = {res[RW-1], res} <<< 1;
      a_n = {acc[RW-1], acc} <<< 1;
      r_n = dbl;
      // Concatenation is unsigned; compare as signed or negatives look large
      if ($signed({res[RW-1], res}) >= conv_pkg::DIGIT_HI) begin
         r_n = dbl - conv_pkg::HALF_SCALE;
         a_n = a_n + 10'sd1;
      end else if ($signed({res[RW-1], res}) < conv_pkg::DIGIT_LO) begin
         r_n = dbl + conv_pkg::HALF_SCALE;
         a_n = a_n - 10'sd1;
      end
      return {r_n[RW-1:0], a_n[RW-1:0]};
   endfunction

   // Final correction: a negative last residue takes one step off
   function automatic logic [SW-1:0] to_code(input logic signed [RW-1:0] res,
                                             input logic signed [RW-1:0] acc);
      logic signed [RW:0] sum;
      sum = {acc[RW-1], acc} + conv_pkg::CODE_OFFSET;
      if (res[RW-1]) begin
         sum = sum - 10'sd1;
      end
      return sum[SW-1:0];
   endfunction

   // Converter clock treated as a synchronous level; edges found by comparison
   assign rise    = conv_clk & ~conv_prev_reg;
   assign fall    = ~conv_clk & conv_prev_reg;
   assign running = (pwr_mode_reg == conv_pkg::PWR_IDLE) ||
                    (pwr_mode_reg == conv_pkg::PWR_NORMAL);

   sample_fifo #(
      .WIDTH (conv_pkg::FIFO_WIDTH),
      .DEPTH (conv_pkg::FIFO_DEPTH)
   ) u_sample_fifo (
      .clk       (core_clk),
      .rst_n     (rst_n),
      .in_valid  (sample_valid),
      .in_ready  (sample_ready),
      .in_data   ({first_channel, second_channel}),
      .out_valid (fifo_valid),
      .out_ready (rise & running),
      .out_data  (fifo_data)
   );

   // Pipeline and output mux
   always_comb begin
      // Starved FIFO repeats the previous pair rather than stalling the clock
      sample_pair      = fifo_valid ? fifo_data : last_sample_reg;
      last_sample_next = last_sample_reg;
      bus_next         = bus_reg;
      indicator_next   = indicator_reg;
      for (int k = 0; k < CL; k++) begin
         res_a_next[k] = res_a_reg[k];
         acc_a_next[k] = acc_a_reg[k];
         res_b_next[k] = res_b_reg[k];
         acc_b_next[k] = acc_b_reg[k];
      end
      if (running && (rise || fall)) begin
         for (int k = 1; k < CL; k++) begin
            if (k <= conv_pkg::PIPE_STAGES) begin
               {res_a_next[k], acc_a_next[k]} = resolve(res_a_reg[k-1], acc_a_reg[k-1]);
               {res_b_next[k], acc_b_next[k]} = resolve(res_b_reg[k-1], acc_b_reg[k-1]);
            end else begin
               res_a_next[k] = res_a_reg[k-1];
               acc_a_next[k] = acc_a_reg[k-1];
               res_b_next[k] = res_b_reg[k-1];
               acc_b_next[k] = acc_b_reg[k-1];
            end
         end
      end
      if (running && rise) begin
         last_sample_next = sample_pair;
         res_a_next[0]    = {sample_pair[2*SW-1], sample_pair[2*SW-1:SW]};
         res_b_next[0]    = {sample_pair[SW-1], sample_pair[SW-1:0]};
         acc_a_next[0]    = '0;
         acc_b_next[0]    = '0;
         bus_next = to_code(res_a_reg[conv_pkg::A_TAP], acc_a_reg[conv_pkg::A_TAP]);
      end else if (running && fall) begin
         bus_next = to_code(res_b_reg[conv_pkg::B_TAP], acc_b_reg[conv_pkg::B_TAP]);
      end
      // Clock distribution runs in every mode but shutdown
      if (pwr_mode_reg != conv_pkg::PWR_SHUTDOWN) begin
         if (rise) begin
            indicator_next = 1'b1;
         end else if (fall) begin
            indicator_next = 1'b0;
         end
      end
   end

   // Power and reference control
   always_comb begin
      case ({power_control_bit0, power_control_bit1})
         conv_pkg::PWR_CODE_SHUTDOWN: pwr_mode_next = conv_pkg::PWR_SHUTDOWN;
         conv_pkg::PWR_CODE_STANDBY:  pwr_mode_next = conv_pkg::PWR_STANDBY;
         conv_pkg::PWR_CODE_IDLE:     pwr_mode_next = conv_pkg::PWR_IDLE;
         conv_pkg::PWR_CODE_NORMAL:   pwr_mode_next = conv_pkg::PWR_NORMAL;
         default:                     pwr_mode_next = conv_pkg::PWR_SHUTDOWN;
      endcase
      ref_scaled    = conv_pkg::REF_CMP_W'(reference_select_input) * conv_pkg::REF_INT_DEN;
      supply_scaled = conv_pkg::REF_CMP_W'(supply_level_mv) * conv_pkg::REF_INT_NUM;
      // Levels between the bands keep the previous mode
      ref_mode_next = ref_mode_reg;
      if (ref_scaled > supply_scaled) begin
         ref_mode_next = conv_pkg::REF_INTERNAL;
      end else if (reference_select_input >= conv_pkg::REF_BUF_LO_MV &&
                   reference_select_input <= conv_pkg::REF_BUF_HI_MV) begin
         ref_mode_next = conv_pkg::REF_BUFFERED;
      end else if (reference_select_input < conv_pkg::REF_UNBUF_MAX_MV) begin
         ref_mode_next = conv_pkg::REF_UNBUFFERED;
      end
      ref_buf_next = (ref_mode_next != conv_pkg::REF_UNBUFFERED) &&
                     (pwr_mode_next != conv_pkg::PWR_SHUTDOWN);
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         conv_prev_reg   <= 1'b0;
         last_sample_reg <= '0;
         bus_reg         <= '0;
         bus_oe_reg      <= 1'b0;
         indicator_reg   <= 1'b0;
         ref_mode_reg    <= conv_pkg::REF_INTERNAL;
         ref_buf_reg     <= 1'b0;
         pwr_mode_reg    <= conv_pkg::PWR_SHUTDOWN;
         for (int k = 0; k < CL; k++) begin
            res_a_reg[k] <= '0;
            acc_a_reg[k] <= '0;
            res_b_reg[k] <= '0;
            acc_b_reg[k] <= '0;
         end
      end else begin
         conv_prev_reg   <= conv_clk;
         last_sample_reg <= last_sample_next;
         // Bus word keeps updating while idle, so enabling shows the latest
         bus_reg         <= bus_next;
         bus_oe_reg      <= (pwr_mode_next == conv_pkg::PWR_NORMAL);
         indicator_reg   <= indicator_next;
         ref_mode_reg    <= ref_mode_next;
         ref_buf_reg     <= ref_buf_next;
         pwr_mode_reg    <= pwr_mode_next;
         for (int k = 0; k < CL; k++) begin
            res_a_reg[k] <= res_a_next[k];
            acc_a_reg[k] <= acc_a_next[k];
            res_b_reg[k] <= res_b_next[k];
            acc_b_reg[k] <= acc_b_next[k];
         end
      end
   end

   assign shared_output_bus    = bus_reg;
   assign shared_output_bus_oe = bus_oe_reg;
   assign channel_indicator    = indicator_reg;
   assign reference_mode       = ref_mode_reg;
   assign reference_buffers_on = ref_buf_reg;
endmodule // dual_channel_muxed_adc_output

`default_nettype wire

// file: logic/conv_pkg.sv
`default_nettype none

package conv_pkg;

   // Word and buffer sizes
   localparam int SAMPLE_W    = 8;
   localparam int RES_W       = 9;
   localparam int FIFO_DEPTH  = 8;
   localparam int FIFO_WIDTH  = 2 * SAMPLE_W;

   // Half-cycle pipeline and output latch alignment
   localparam int PIPE_STAGES      = 7;
   localparam int A_LATENCY_HALVES = 10;
   localparam int B_LATENCY_HALVES = 11;
   localparam int A_TAP            = A_LATENCY_HALVES - 1;
   localparam int B_TAP            = B_LATENCY_HALVES - 1;
   localparam int CHAIN_LEN        = B_LATENCY_HALVES;

   // Redundant 1.5-bit stage thresholds, in input steps
   localparam logic signed [RES_W:0] DIGIT_HI   = 10'sd32;
   localparam logic signed [RES_W:0] DIGIT_LO   = -10'sd32;
   localparam logic signed [RES_W:0] HALF_SCALE = 10'sd128;
   localparam logic signed [RES_W:0] CODE_OFFSET = 10'sd128;

   // Reference select thresholds in millivolts
   localparam int REF_IN_W  = 11;
   localparam int SUPPLY_W  = 12;
   localparam int REF_CMP_W = 15;
   localparam logic [REF_IN_W-1:0]  REF_UNBUF_MAX_MV = 11'd300;
   localparam logic [REF_IN_W-1:0]  REF_BUF_LO_MV    = 11'd922;
   localparam logic [REF_IN_W-1:0]  REF_BUF_HI_MV    = 11'd1126;
   localparam logic [REF_CMP_W-1:0] REF_INT_DEN      = 15'd5;
   localparam logic [REF_CMP_W-1:0] REF_INT_NUM      = 15'd4;

   // Power control code, bit0 then bit1
   localparam logic [1:0] PWR_CODE_SHUTDOWN = 2'h0;
   localparam logic [1:0] PWR_CODE_STANDBY  = 2'h1;
   localparam logic [1:0] PWR_CODE_IDLE     = 2'h2;
   localparam logic [1:0] PWR_CODE_NORMAL   = 2'h3;

   typedef enum logic [2:0] {
      REF_INTERNAL   = 3'b001,
      REF_BUFFERED   = 3'b010,
      REF_UNBUFFERED = 3'b100
   } ref_mode_t;

   typedef enum logic [3:0] {
      PWR_SHUTDOWN = 4'b0001,
      PWR_STANDBY  = 4'b0010,
      PWR_IDLE     = 4'b0100,
      PWR_NORMAL   = 4'b1000
   } power_mode_t;

endpackage

`default_nettype wire

// file: test/adc_out_assertions.sv
`default_nettype none
module adc_out_checker (
   input wire logic                          core_clk,
   input wire logic                          rst_n,
   input wire logic                          conv_clk,
   input wire logic                          power_control_bit0,
   input wire logic                          power_control_bit1,
   input wire logic [conv_pkg::REF_IN_W-1:0] reference_select_input,
   input wire logic [conv_pkg::SUPPLY_W-1:0] supply_level_mv,
   input wire logic [conv_pkg::SAMPLE_W-1:0] shared_output_bus,
   input wire logic                          shared_output_bus_oe,
   input wire logic                          channel_indicator,
   input wire logic [2:0]                    reference_mode,
   input wire logic                          reference_buffers_on
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   logic pwr_on;
   logic ref_int;
   logic ref_band;
   assign pwr_on = power_control_bit0 | power_control_bit1;
   assign ref_int = 15'(reference_select_input) * 15'h5 > 15'(supply_level_mv) * 15'h4;
   assign ref_band = reference_select_input >= 11'h39a && reference_select_input <= 11'h466;
   // Power decode must be settled for two edges before an edge counts
   sequence s_rise;
      rst_n && pwr_on ##1 pwr_on && !conv_clk ##1 conv_clk && pwr_on;
   endsequence
   sequence s_fall;
      rst_n && pwr_on ##1 pwr_on && conv_clk ##1 !conv_clk && pwr_on;
   endsequence
   AST_IND_RISE: assert property (s_rise |=> channel_indicator)
      else $error("indicator not high after clock rise");
   AST_IND_FALL: assert property (s_fall |=> !channel_indicator)
      else $error("indicator not low after clock fall");
   AST_IND_STEADY: assert property ($past(rst_n) && $past(rst_n, 2) &&
      $changed(channel_indicator) |-> $past(conv_clk) != $past(conv_clk, 2))
      else $error("indicator moved without a clock edge");
   AST_BUS_STEADY: assert property ($past(rst_n) && $past(rst_n, 2) &&
      $changed(shared_output_bus) |-> $past(conv_clk) != $past(conv_clk, 2))
      else $error("bus moved without a clock edge");
   AST_OE_NORMAL: assert property (power_control_bit0 && power_control_bit1
      |=> shared_output_bus_oe) else $error("bus not driven in normal mode");
   AST_OE_OFF: assert property (!(power_control_bit0 && power_control_bit1)
      |=> !shared_output_bus_oe) else $error("bus driven outside normal mode");
   AST_REF_UNBUF: assert property ((reference_select_input < 11'h12c) [*2] |=>
      reference_mode == 3'h4 && !reference_buffers_on) else $error("unbuffered mode wrong");
   AST_REF_INT: assert property ((ref_int && reference_select_input > 11'h466) [*2]
      |=> reference_mode == 3'h1) else $error("internal mode not chosen");
   AST_REF_BUF: assert property ((ref_band && !ref_int) [*2] |=>
      reference_mode == 3'h2) else $error("buffered mode not chosen");
endmodule // adc_out_checker

bind dual_channel_muxed_adc_output adc_out_checker u_adc_out_checker (
   .core_clk(core_clk), .rst_n(rst_n), .conv_clk(conv_clk),
   .power_control_bit0(power_control_bit0), .power_control_bit1(power_control_bit1),
   .reference_select_input(reference_select_input), .supply_level_mv(supply_level_mv),
   .shared_output_bus(shared_output_bus), .shared_output_bus_oe(shared_output_bus_oe),
   .channel_indicator(channel_indicator), .reference_mode(reference_mode),
   .reference_buffers_on(reference_buffers_on)
);
`default_nettype wire

// file: test/host_capture.sv
`default_nettype none
module host_capture (
   input  wire logic       core_clk,
   input  wire logic       run,
   output logic            conv_clk = 1'b0,
   input  wire logic [7:0] shared_output_bus,
   input  wire logic       shared_output_bus_oe,
   input  wire logic       channel_indicator
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] a_q[$];
   logic [7:0] b_q[$];
   logic       ind_prev = 1'b0;
   int         cnt = 0;
   // Four core cycles per level; stops only when low, so no runt pulse
   always @(posedge core_clk) begin
      if (run || conv_clk) begin
         cnt <= (cnt == 3) ? 0 : cnt + 1;
         if (cnt == 3) conv_clk <= #1 ~conv_clk;
      end else begin
         cnt <= 0;
      end
   end
   // Words split into two streams by indicator level
   always @(posedge core_clk) begin
      if (shared_output_bus_oe === 1'b1 && channel_indicator !== ind_prev) begin
         if (channel_indicator) a_q.push_back(shared_output_bus);
         else b_q.push_back(shared_output_bus);
      end
      ind_prev = channel_indicator;
   end
endmodule // host_capture
`default_nettype wire

// file: test/tb_top.sv
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        run = 1'b0;
   logic        conv_clk;
   logic        sample_valid = 1'b0;
   logic        sample_ready;
   logic [7:0]  first_channel = 8'h00;
   logic [7:0]  second_channel = 8'h00;
   logic        power_control_bit0 = 1'b1;
   logic        power_control_bit1 = 1'b1;
   logic [10:0] reference_select_input = 11'h7d0;
   logic [11:0] supply_level_mv = 12'h7d0;
   logic [7:0]  shared_output_bus;
   logic        shared_output_bus_oe;
   logic        channel_indicator;
   logic [2:0]  reference_mode;
   logic        reference_buffers_on;
   int          error_cnt = 0;
   int          n_tests = 0;
   logic [7:0]  a_s [8] = '{8'h7f, 8'h80, 8'h00, 8'h01, 8'hff, 8'h40, 8'hc0, 8'h25};

   always #10 core_clk = ~core_clk;

   dual_channel_muxed_adc_output u_dual_channel_muxed_adc_output (
      .core_clk(core_clk), .rst_n(rst_n), .conv_clk(conv_clk),
      .sample_valid(sample_valid), .sample_ready(sample_ready),
      .first_channel(first_channel), .second_channel(second_channel),
      .power_control_bit0(power_control_bit0), .power_control_bit1(power_control_bit1),
      .reference_select_input(reference_select_input), .supply_level_mv(supply_level_mv),
      .shared_output_bus(shared_output_bus), .shared_output_bus_oe(shared_output_bus_oe),
      .channel_indicator(channel_indicator), .reference_mode(reference_mode),
      .reference_buffers_on(reference_buffers_on));
   host_capture u_host_capture (
      .core_clk(core_clk), .run(run), .conv_clk(conv_clk),
      .shared_output_bus(shared_output_bus), .shared_output_bus_oe(shared_output_bus_oe),
      .channel_indicator(channel_indicator));

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic t_reset();
      cyc(2);
      chk({1'b0, reference_mode, reference_buffers_on, shared_output_bus_oe,
           channel_indicator, sample_ready}, 8'h10, "state in reset");
      rst_n = 1'b1;
      cyc(1);
      chk(8'(sample_ready), 8'h01, "ready after reset");
      $display("reset test done");
   endtask
   task automatic t_power();
      for (int c = 0; c < 4; c++) begin
         power_control_bit0 = c[1];
         power_control_bit1 = c[0];
         cyc(2);
         chk(8'(shared_output_bus_oe), 8'(c == 3), "enable per power code");
      end
      $display("power test done");
   endtask
   task automatic t_ref();
      logic [10:0] lv [7] = '{11'h7d0, 11'h400, 11'h12b, 11'h258, 11'h39a, 11'h466, 11'h7d0};
      logic [3:0]  ex [7] = '{4'h3, 4'h5, 4'h8, 4'h8, 4'h5, 4'h5, 4'h3};
      for (int i = 0; i < 7; i++) begin
         reference_select_input = lv[i];
         cyc(3);
         chk({4'h0, reference_mode, reference_buffers_on}, {4'h0, ex[i]}, "ref mode");
      end
      $display("reference test done");
   endtask
   task automatic t_stream();
      int k = 0;
      int n = 0;
      u_host_capture.a_q.delete();
      u_host_capture.b_q.delete();
      sample_valid = 1'b1;
      while (k < 8 && n < 40) begin
         first_channel = a_s[k];
         second_channel = a_s[7-k];
         @(posedge core_clk);
         if (sample_ready === 1'b1) k++;
         n++;
         #1;
      end
      first_channel = 8'h55;
      cyc(3);
      chk(8'(sample_ready), 8'h00, "full buffer refuses");
      sample_valid = 1'b0;
      run = 1'b1;
      for (n = 0; n < 400 && u_host_capture.b_q.size() < 14; n++) cyc(1);
      run = 1'b0;
      cyc(8);
      for (k = 0; k < 8; k++) begin
         chk(u_host_capture.a_q[5+k], a_s[k] ^ 8'h80, "A word five cycles on");
         chk(u_host_capture.b_q[5+k], a_s[7-k] ^ 8'h80, "B word half cycle on");
      end
      chk(u_host_capture.a_q[13], a_s[7] ^ 8'h80, "empty buffer repeats pair");
      $display("stream test done");
   endtask
   task automatic t_wake();
      power_control_bit1 = 1'b0;
      first_channel = 8'h12;
      second_channel = 8'h34;
      sample_valid = 1'b1;
      cyc(1);
      sample_valid = 1'b0;
      run = 1'b1;
      cyc(50);
      run = 1'b0;
      cyc(8);
      chk(8'(shared_output_bus_oe), 8'h00, "idle keeps bus off");
      power_control_bit1 = 1'b1;
      cyc(2);
      chk(shared_output_bus, 8'hb4, "last word on wake");
      $display("wake test done");
   endtask
   task automatic t_standby();
      power_control_bit0 = 1'b0;
      run = 1'b1;
      cyc(7);
      // Clock high here: a running pipeline would show the A word
      chk(8'(channel_indicator), 8'h01, "indicator follows clock in standby");
      chk(shared_output_bus, 8'hb4, "standby freezes bus");
      run = 1'b0;
      cyc(12);
      power_control_bit0 = 1'b1;
      cyc(2);
      chk(8'(shared_output_bus_oe), 8'h01, "normal drives bus");
      chk(shared_output_bus, 8'hb4, "last word after standby");
      $display("standby test done");
   endtask

   initial begin
      t_reset();
      t_power();
      t_ref();
      t_stream();
      t_wake();
      t_standby();
      wrap_up();
   end
   // Whole run is under 20 us; five times that marks a hang
   initial begin
      #100us;
      error_cnt++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      wrap_up();
   end
endmodule // tb_top
`default_nettype wire
